// [src/flash_prot_defines.svh]
// Constants of the flash protection and security block
`ifndef FLASH_PROT_DEFINES_SVH
`define FLASH_PROT_DEFINES_SVH
`define FP_NUM_BLOCKS       6
`define FP_OFF_CTRL_STATUS  32'h40040520
`define FP_OFF_SECURITY     32'h40040500
`define FP_OFF_IRQ_STATUS   32'h40040524
`define FP_OFF_IRQ_MASK     32'h40040528
`define FP_OFF_STATE        32'h4004052C
`define FP_RDY_BIT          0
`define FP_PROT_LSB         16
`define FP_PROT_MSB         21
`define FP_GRP_HI_BIT       18
`define FP_GRP_LO_BIT       17
`define FP_IDSEL_HI_BIT     15
`define FP_IDSEL_LO_BIT     14
`define FP_CMD_PAGE_HI      8'h54
`define FP_CMD_PAGE_LO      8'h55
`define FP_GROUP0_MASK      6'h0F
`define FP_GROUP1_MASK      6'h30
`define FP_SEC_RESET        1'b1
// Identification codes and default operation length in cycles: arbitrary values
`define FP_MAKER_CODE       8'h3C
`define FP_DEVICE_CODE      8'h4D
`define FP_MACRO_CODE       8'h21
`define FP_OP_CYCLES        16'h0040
`endif

// [src/flash_prot_pkg.sv]
// Types of the flash protection and security block
package flash_prot_pkg;
  typedef enum logic [1:0] {MODE_SINGLE_CHIP, MODE_SINGLE_BOOT, MODE_WRITER} boot_mode_t;
  typedef enum logic [2:0] {OP_NONE, OP_PROGRAM, OP_ERASE, OP_PB_PROGRAM, OP_PB_ERASE,
                            OP_ID_READ} flash_op_t;
  typedef struct packed {
    logic        valid;
    flash_op_t   op;
    logic [31:0] addr;
    logic [2:0]  block;
  } flash_cmd_t;
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axil_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;
endpackage : flash_prot_pkg

// [src/flash_id_decode.sv]
// Identification code lookup from the id select address
`timescale 1ns/1ns
`include "flash_prot_defines.svh"
module flash_id_decode (
  input  wire logic [1:0] i_id_select_address,
  output logic      [7:0] o_id_read_value
);
  import flash_prot_pkg::*;
  always_comb begin
    case (i_id_select_address)
      2'b00:   o_id_read_value = `FP_MAKER_CODE;
      2'b01:   o_id_read_value = `FP_DEVICE_CODE;
      2'b11:   o_id_read_value = `FP_MACRO_CODE;
      default: o_id_read_value = 8'h00;
    endcase
  end
endmodule : flash_id_decode

// [src/flash_axil_slave.sv]
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/1ns
module flash_axil_slave (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  input  wire flash_prot_pkg::axil_req_t i_req,
  output flash_prot_pkg::axil_rsp_t     o_rsp,
  output logic                          o_wr_en,
  output logic [31:0]                   o_wr_addr,
  output logic [31:0]                   o_wr_data,
  output logic                          o_rd_en,
  output logic [31:0]                   o_rd_addr,
  input  wire logic [31:0]              i_rd_data,
  input  wire logic                     i_rd_ok,
  input  wire logic                     i_wr_ok
);
  import flash_prot_pkg::*;
  typedef struct packed {
    logic        aw_have;
    logic [31:0] awaddr;
    logic        w_have;
    logic [31:0] wdata;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } st_t;
  st_t s_q, s_d;
  logic wr_go, rd_go;
  assign wr_go     = s_q.aw_have && s_q.w_have && !s_q.bvalid;
  assign rd_go     = i_req.arvalid && !s_q.rvalid;
  assign o_wr_en   = wr_go;
  assign o_wr_addr = s_q.awaddr;
  assign o_wr_data = s_q.wdata;
  assign o_rd_en   = rd_go;
  assign o_rd_addr = i_req.araddr;
  always_comb begin
    s_d = s_q;
    if (i_req.awvalid && !s_q.aw_have) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr  = i_req.awaddr;
    end
    if (i_req.wvalid && !s_q.w_have) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = i_req.wdata;
    end
    if (wr_go) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = i_wr_ok ? 2'h0 : 2'h2;
    end else if (s_q.bvalid && i_req.bready) begin
      s_d.bvalid = 1'b0;
    end
    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = i_rd_data;
      s_d.rresp  = i_rd_ok ? 2'h0 : 2'h2;
    end else if (s_q.rvalid && i_req.rready) begin
      s_d.rvalid = 1'b0;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  always_comb begin
    o_rsp.awready = !s_q.aw_have;
    o_rsp.wready  = !s_q.w_have;
    o_rsp.bvalid  = s_q.bvalid;
    o_rsp.bresp   = s_q.bresp;
    o_rsp.arready = !s_q.rvalid;
    o_rsp.rvalid  = s_q.rvalid;
    o_rsp.rdata   = s_q.rdata;
    o_rsp.rresp   = s_q.rresp;
  end
endmodule : flash_axil_slave

// [src/flash_protection_security.sv]
// Flash write/erase protection and security gating
`timescale 1ns/1ns
`include "flash_prot_defines.svh"
module flash_protection_security #(
  parameter int NUM_BLOCKS = `FP_NUM_BLOCKS,
  parameter logic [15:0] OP_CYCLES = `FP_OP_CYCLES
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_por_n,
  input  wire flash_prot_pkg::boot_mode_t i_boot_mode,
  input  wire flash_prot_pkg::flash_cmd_t i_cmd,
  input  wire logic                       i_op_fail,
  input  wire logic                       i_rom_rd,
  input  wire logic [31:0]                i_rom_rdata,
  output logic [31:0]                     o_rom_rdata,
  output logic                            o_cmd_accept,
  output logic                            o_cmd_refused,
  output logic [7:0]                      o_id_read_value,
  output logic                            o_debug_enable,
  output logic                            o_trace_enable,
  output logic                            o_security_active,
  input  wire flash_prot_pkg::axil_req_t  i_axil_req,
  output flash_prot_pkg::axil_rsp_t       o_axil_rsp,
  output logic                            o_irq
);
  import flash_prot_pkg::*;
  // Nonvolatile state, reset only by power-on
  typedef struct packed {
    logic [5:0] block_protect_bits;
    logic       security_enable_bit;
  } nv_t;
  typedef struct packed {
    logic        auto_op_ready;
    logic        failed;
    logic [15:0] busy_cnt;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic [7:0]  id_q;
    logic [31:0] rom_q;
    logic        accept_q;
    logic        refuse_q;
  } st_t;
  nv_t nv_q, nv_d;
  st_t s_q, s_d;
  logic        wr_en, rd_en, rd_ok;
  logic [31:0] wr_addr, wr_data, rd_addr, rd_data;
  logic [7:0]  id_val;
  logic        secure, blk_prot, allowed, refused, done_ev;
  logic [5:0]  grp_mask;

  function automatic logic [5:0] group_mask(input logic [31:0] addr);
    case ({addr[`FP_GRP_HI_BIT], addr[`FP_GRP_LO_BIT]})
      2'b00:   group_mask = `FP_GROUP0_MASK;
      2'b01:   group_mask = `FP_GROUP1_MASK;
      default: group_mask = 6'h00;
    endcase
  endfunction : group_mask

  assign secure   = nv_q.security_enable_bit && (&nv_q.block_protect_bits);
  assign blk_prot = nv_q.block_protect_bits[i_cmd.block];
  assign grp_mask = group_mask(i_cmd.addr);

  always_comb begin
    allowed = 1'b0;
    if (i_cmd.valid && s_q.auto_op_ready && !s_q.failed) begin
      case (i_cmd.op)
        OP_PROGRAM, OP_ERASE: allowed = !secure && !blk_prot;
        OP_PB_PROGRAM:        allowed = !secure;
        OP_PB_ERASE:          allowed = 1'b1;
        OP_ID_READ:           allowed = !secure;
        default:              allowed = 1'b0;
      endcase
    end
  end
  assign refused = i_cmd.valid && !allowed;
  assign done_ev = !s_q.auto_op_ready && !s_q.failed && (s_q.busy_cnt == 16'h0001);

  flash_id_decode u_id (
    .i_id_select_address (i_cmd.addr[`FP_IDSEL_HI_BIT:`FP_IDSEL_LO_BIT]),
    .o_id_read_value     (id_val)
  );

  flash_axil_slave u_bus (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_req     (i_axil_req),
    .o_rsp     (o_axil_rsp),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_rd_en   (rd_en),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_ok   (rd_ok),
    .i_wr_ok   (1'b1)
  );

  always_comb begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    case (rd_addr)
      `FP_OFF_CTRL_STATUS: begin
        rd_data[`FP_PROT_MSB:`FP_PROT_LSB] = nv_q.block_protect_bits;
        rd_data[`FP_RDY_BIT] = s_q.auto_op_ready;
      end
      `FP_OFF_SECURITY:   rd_data[0]   = nv_q.security_enable_bit;
      `FP_OFF_IRQ_STATUS: rd_data[1:0] = s_q.irq_status;
      `FP_OFF_IRQ_MASK:   rd_data[1:0] = s_q.irq_mask;
      `FP_OFF_STATE:      rd_data[0]   = secure;
      default:            rd_ok        = 1'b0;
    endcase
  end

  always_comb begin
    nv_d = nv_q;
    if (allowed) begin
      case (i_cmd.op)
        OP_PB_PROGRAM: nv_d.block_protect_bits[i_cmd.block] = 1'b1;
        OP_PB_ERASE: begin
          if (secure) begin
            nv_d.block_protect_bits  = 6'h00;
            nv_d.security_enable_bit = 1'b0;
          end else begin
            nv_d.block_protect_bits = nv_q.block_protect_bits & ~grp_mask;
          end
        end
        default: nv_d = nv_q;
      endcase
    end
    if (wr_en && wr_addr == `FP_OFF_SECURITY) begin
      nv_d.security_enable_bit = wr_data[0];
    end
  end

  always_comb begin
    s_d          = s_q;
    s_d.accept_q = allowed;
    s_d.refuse_q = refused;
    if (allowed && i_cmd.op == OP_ID_READ) begin
      s_d.id_q = id_val;
    end
    if (i_rom_rd) begin
      s_d.rom_q = (secure && i_boot_mode == MODE_WRITER) ?
                  {24'h000000, `FP_MAKER_CODE} : i_rom_rdata;
    end
    if (allowed && i_cmd.op != OP_ID_READ) begin
      s_d.auto_op_ready = 1'b0;
      s_d.busy_cnt      = OP_CYCLES;
    end else if (!s_q.auto_op_ready && !s_q.failed) begin
      if (i_op_fail) begin
        s_d.failed = 1'b1;
      end else if (s_q.busy_cnt == 16'h0001) begin
        s_d.auto_op_ready = 1'b1;
      end else begin
        s_d.busy_cnt = s_q.busy_cnt - 16'h0001;
      end
    end
    if (wr_en && wr_addr == `FP_OFF_IRQ_STATUS) begin
      s_d.irq_status = s_q.irq_status & ~wr_data[1:0];
    end
    if (wr_en && wr_addr == `FP_OFF_IRQ_MASK) begin
      s_d.irq_mask = wr_data[1:0];
    end
    if (done_ev) begin
      s_d.irq_status[0] = 1'b1;
    end
    if (refused) begin
      s_d.irq_status[1] = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      nv_q.block_protect_bits  <= 6'h00;
      nv_q.security_enable_bit <= `FP_SEC_RESET;
    end else begin
      nv_q <= nv_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q               <= '0;
      s_q.auto_op_ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_security_active = secure;
  assign o_debug_enable    = !secure;
  assign o_trace_enable    = !secure;
  assign o_cmd_accept      = s_q.accept_q;
  assign o_cmd_refused     = s_q.refuse_q;
  assign o_id_read_value   = s_q.id_q;
  assign o_rom_rdata       = s_q.rom_q;
  assign o_irq             = |(s_q.irq_status & s_q.irq_mask);

  a_prot_refuse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_cmd.valid && (i_cmd.op == OP_PROGRAM) && blk_prot |=> o_cmd_refused)
    else $error("protected block program accepted");
  a_secure_def: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    secure == (nv_q.security_enable_bit && (&nv_q.block_protect_bits)))
    else $error("security state wrong");
  a_debug_block: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    secure |-> !o_debug_enable && !o_trace_enable)
    else $error("debug open while secure");
  a_secure_ignore: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    secure && i_cmd.valid && i_cmd.op == OP_ERASE |=> !o_cmd_accept && $stable(nv_q))
    else $error("command taken while secure");
  a_pb_erase_all: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    secure && allowed && i_cmd.op == OP_PB_ERASE |=> nv_q.block_protect_bits == 6'h00)
    else $error("secure erase left bits");
  a_group_erase: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !secure && allowed && i_cmd.op == OP_PB_ERASE && grp_mask == 6'h0F
    |=> nv_q.block_protect_bits[5:4] == $past(nv_q.block_protect_bits[5:4]))
    else $error("group erase hit other group");
  a_rom_mask: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_rom_rd && secure && i_boot_mode == MODE_WRITER
    |=> o_rom_rdata == {24'h000000, `FP_MAKER_CODE})
    else $error("secure rom read leaked");
  a_pb_program: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    allowed && i_cmd.op == OP_PB_PROGRAM |=> nv_q.block_protect_bits[$past(i_cmd.block)])
    else $error("protect bit not set");
  a_busy_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_q.failed |=> !s_q.auto_op_ready)
    else $error("ready after failure");
endmodule : flash_protection_security

// [bench/flash_host_model.sv]
// Host model that issues flash command sequences
`timescale 1ns/1ns
`include "flash_prot_defines.svh"
module flash_host_model (
  input  wire logic                  i_clk,
  output flash_prot_pkg::flash_cmd_t o_cmd
);
  import flash_prot_pkg::*;
  initial o_cmd = '0;
  // One-cycle strobe; the payload is scrambled once released
  task automatic send(input flash_op_t op, input logic [2:0] blk, input logic [31:0] a);
    logic [31:0] full;
    full = a;
    if (op == OP_PROGRAM || op == OP_ERASE) full[15:8] = `FP_CMD_PAGE_HI;
    @(posedge i_clk);
    o_cmd <= '{valid: 1'b1, op: op, addr: full, block: blk};
    @(posedge i_clk);
    o_cmd <= '{valid: 1'b0, op: OP_NONE, addr: ~full, block: ~blk};
  endtask : send
endmodule : flash_host_model

// [bench/testbench.sv]
// Self-checking bench for the flash protection and security block
`timescale 1ns/1ns
`include "flash_prot_defines.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  import flash_prot_pkg::*;
  localparam logic [15:0] OPC   = 16'h0010;
  localparam logic [31:0] A_ST  = `FP_OFF_CTRL_STATUS;
  localparam logic [31:0] A_SEC = `FP_OFF_SECURITY;
  localparam logic [31:0] A_IRQ = `FP_OFF_IRQ_STATUS;
  localparam logic [31:0] A_MSK = `FP_OFF_IRQ_MASK;
  localparam logic [31:0] A_ACT = `FP_OFF_STATE;
  logic        clk = 1'b0, rst_n = 1'b0, por_n = 1'b0, op_fail = 1'b0, rom_rd = 1'b0;
  logic [31:0] rom_in = 32'h0, rom_out;
  boot_mode_t  mode = MODE_SINGLE_CHIP;
  flash_cmd_t  cmd;
  axil_req_t   req = '0;
  axil_rsp_t   rsp;
  logic        acc, refd, sec, dbg, trc, irq, id_p = 1'b0, rom_p = 1'b0;
  logic [7:0]  idv, id_e;
  logic [5:0]  prot = 6'h00;
  logic [7:0]  ids [4] = '{`FP_MAKER_CODE, `FP_DEVICE_CODE, 8'h00, `FP_MACRO_CODE};
  logic [33:0] exp_rd [$];
  logic [10:0] exp_cmd [$];
  logic [31:0] exp_rom [$];
  int          bad_count = 0, tests_run = 0;
  always #5 clk = ~clk;
  flash_protection_security #(.OP_CYCLES(OPC)) u_flash_protection_security (
    .i_clk(clk), .i_rst_n(rst_n), .i_por_n(por_n), .i_boot_mode(mode), .i_cmd(cmd),
    .i_op_fail(op_fail), .i_rom_rd(rom_rd), .i_rom_rdata(rom_in), .o_rom_rdata(rom_out),
    .o_cmd_accept(acc), .o_cmd_refused(refd), .o_id_read_value(idv),
    .o_debug_enable(dbg), .o_trace_enable(trc), .o_security_active(sec),
    .i_axil_req(req), .o_axil_rsp(rsp), .o_irq(irq));
  flash_host_model u_host (.i_clk(clk), .o_cmd(cmd));
  // Result watcher: oldest note against each result that appears
  always @(posedge clk) begin : watch
    logic [10:0] n;
    logic [33:0] r;
    id_p <= 1'b0;
    rom_p <= rom_rd;
    if (rsp.rvalid && req.rready) begin
      r = exp_rd.size() ? exp_rd.pop_front() : '1;
      `CHK("rdata", r, {rsp.rresp, rsp.rdata})
    end
    if (acc || refd) begin
      n = exp_cmd.size() ? exp_cmd.pop_front() : '1;
      `CHK("outcome", n[9:8], {acc, refd})
      id_p <= n[10];
      id_e <= n[7:0];
    end
    if (id_p) `CHK("id", id_e, idv)
    if (rom_p) `CHK("rom", exp_rom.pop_front(), rom_out)
  end
  task automatic test_done;
    `CHK("pending", 0, exp_rd.size() + exp_cmd.size() + exp_rom.size())
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hF, bready: 1'b1,
             default: '0};
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    req.bready <= 1'b0;
    `CHK("bresp", 2'b00, rsp.bresp)
    if (n == 50) begin bad_count++; test_done(); end
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    int n;
    exp_rd.push_back(e);
    @(posedge clk);
    req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    req.rready <= 1'b0;
    if (n == 50) begin bad_count++; test_done(); end
  endtask : rd
  task automatic st(input logic rdy);
    rd(A_ST, {2'b00, 10'h000, prot, 15'h0000, rdy});
  endtask : st
  task automatic op(input flash_op_t o, input logic [2:0] b, input logic [31:0] a,
                    input logic ok, input int w = OPC + 8, input logic [7:0] id = 8'h00);
    exp_cmd.push_back({o == OP_ID_READ && ok, ok, !ok, id});
    u_host.send(o, b, a);
    repeat (w) @(posedge clk);
  endtask : op
  task automatic rom(input logic [31:0] d, input logic masked);
    exp_rom.push_back(masked ? {24'h000000, `FP_MAKER_CODE} : d);
    @(posedge clk);
    rom_rd <= 1'b1;
    rom_in <= d;
    @(posedge clk);
    rom_rd <= 1'b0;
    rom_in <= ~d;
  endtask : rom
  initial begin : main
    int m;
    void'($urandom(32'hEA34));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    st(1'b1);
    rd(A_SEC, {2'b00, 32'h00000001});
    rd(A_ACT, {2'b00, 32'h00000000});
    `CHK("secure", 3'b011, {sec, dbg, trc})
    rd(32'h40040530, {2'b10, 32'h00000000});
    wr(32'h40040530, 32'hFFFFFFFF);
    wr(A_ST, 32'hFFFFFFFF);
    st(1'b1);
    wr(A_MSK, 32'h00000003);
    for (m = 0; m < 6; m++) if (m == 0 || m > 3) begin
      op(OP_PB_PROGRAM, 3'(m), 32'h0, 1'b1);
      prot[m] = 1'b1;
    end
    st(1'b1);
    for (m = 0; m < 3; m++) begin
      mode <= boot_mode_t'(m);
      op(OP_PROGRAM, 3'd0, 32'h0, 1'b0);
      op(OP_ERASE, 3'd5, 32'h0, 1'b0);
    end
    mode <= MODE_SINGLE_CHIP;
    op(OP_PROGRAM, 3'd1, 32'h0, 1'b1);
    `CHK("irq", 1'b1, irq)
    rd(A_IRQ, {2'b00, 32'h00000003});
    wr(A_IRQ, 32'h00000003);
    `CHK("irq", 1'b0, irq)
    wr(A_MSK, 32'h00000000);
    op(OP_ERASE, 3'd4, 32'h0, 1'b0);
    `CHK("irq", 1'b0, irq)
    rd(A_IRQ, {2'b00, 32'h00000002});
    wr(A_IRQ, 32'h00000002);
    op(OP_PB_ERASE, 3'd0, 32'h1 << `FP_GRP_LO_BIT, 1'b1);
    prot[5:4] = 2'b00;
    st(1'b1);
    op(OP_PB_ERASE, 3'd0, 32'h0, 1'b1);
    prot[3:0] = 4'h0;
    st(1'b1);
    for (m = 0; m < 4; m++) op(OP_ID_READ, 3'd0, {m[1:0], 14'($urandom())}, 1'b1, 8, ids[m]);
    for (m = 0; m < 6; m++) op(OP_PB_PROGRAM, 3'(m), 32'h0, 1'b1);
    prot = 6'h3F;
    `CHK("secure", 3'b100, {sec, dbg, trc})
    rd(A_ACT, {2'b00, 32'h00000001});
    wr(A_SEC, 32'h00000000);
    `CHK("secure", 3'b011, {sec, dbg, trc})
    wr(A_SEC, 32'h00000001);
    `CHK("secure", 3'b100, {sec, dbg, trc})
    rom($urandom(), 1'b0);
    mode <= MODE_WRITER;
    rom($urandom(), 1'b1);
    mode <= MODE_SINGLE_BOOT;
    rom($urandom(), 1'b0);
    op(OP_ERASE, 3'd1, 32'h0, 1'b0);
    op(OP_PB_PROGRAM, 3'd2, 32'h0, 1'b0);
    op(OP_PB_ERASE, 3'd0, 32'h1 << `FP_GRP_LO_BIT, 1'b1);
    prot = 6'h00;
    st(1'b1);
    rd(A_SEC, {2'b00, 32'h00000000});
    `CHK("secure", 3'b011, {sec, dbg, trc})
    op(OP_PB_PROGRAM, 3'd3, 32'h0, 1'b1);
    prot[3] = 1'b1;
    op(OP_PROGRAM, 3'd1, 32'h0, 1'b1, 2);
    st(1'b0);
    op_fail <= 1'b1;
    @(posedge clk);
    op_fail <= 1'b0;
    repeat (OPC + 8) @(posedge clk);
    st(1'b0);
    op(OP_PROGRAM, 3'd1, 32'h0, 1'b0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    st(1'b1);
    rd(A_SEC, {2'b00, 32'h00000000});
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule : testbench
